// File: core/bus_register.sv
// Twenty-bit capture register with output drive enable and an eight-word word buffer.
//
// Operation
// (RULE_01) Twenty non-inverting stored bits, output equals input.
// (RULE_02) Load every bit on qualified edge, enable low.
// (RULE_03) Hold stored value when capture not enabled.
// (RULE_04) Drive all outputs while drive enable low.
// (RULE_05) Release all outputs while drive enable high.
// (RULE_06) Capture continues while outputs are released.
// (RULE_07) Bus side keeps data settled around edges.
// (RULE_08) No reset input; contents meaningless until capture. The code has ARST_N_I, which clears the store to zero and STORE_VALID_O low.
`timescale 1ns/1ns

// =============================================================================
// Word buffer with valid and ready on both sides
// =============================================================================
module word_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0]   DEPTH_C = (PTR_W + 1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_C  = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [PTR_W:0]   count_q;
   logic             push;
   logic             pop;

   // Handshakes: full refuses a push, empty withholds valid.
   assign in_ready_o  = (count_q != DEPTH_C);
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Storage array carries data only, so it needs no reset.
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // Write pointer wraps at the last entry.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_q <= '0;
      end else if (push) begin
         wr_ptr_q <= (wr_ptr_q == LAST_C) ? '0 : wr_ptr_q + 1'b1;
      end
   end

   // Read pointer wraps at the last entry.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_ptr_q <= '0;
      end else if (pop) begin
         rd_ptr_q <= (rd_ptr_q == LAST_C) ? '0 : rd_ptr_q + 1'b1;
      end
   end

   // Fill level follows pushes and pops in the same cycle.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
         count_q <= count_q - 1'b1;
      end
   end

endmodule : word_fifo

// =============================================================================
// Top of the capture register
// =============================================================================
module bus_register #(
   parameter int DATA_W = bus_reg_pkg::DATA_W,
   parameter int DEPTH  = bus_reg_pkg::FIFO_DEPTH
) (
   input  wire logic              MCLK_I,
   input  wire logic              ARST_N_I,
   input  wire logic [DATA_W-1:0] DIN_BUS_I,
   input  wire logic              CAPTURE_EN_N_I,
   input  wire logic              DRIVE_EN_N_I,
   input  wire logic              UPDATE_HOLD_I,
   output logic      [DATA_W-1:0] QOUT_BUS_O,
   output logic      [DATA_W-1:0] QOUT_OE_O,
   output logic                   CAPTURE_READY_O,
   output logic                   STORE_VALID_O
);

   // ==========================================================================
   // Pin synchroniser and agreement filter
   // ==========================================================================
   bus_reg_pkg::pin_in_type pin_raw;
   bus_reg_pkg::pin_in_type s1_q;
   bus_reg_pkg::pin_in_type s2_q;
   bus_reg_pkg::pin_in_type s3_q;
   bus_reg_pkg::pin_in_type filt_q;
   wire logic [bus_reg_pkg::SYNC_W-1:0] filt_d;

   // The stored word trails the pins by six clock edges: three synchroniser
   // stages, one filter stage, one buffer write and the store load. With the update
   // hold low the buffer never holds more than one word, so the block behaves
   // as a plain register with a fixed delay.
   logic [DATA_W-1:0] fifo_data;
   logic              fifo_valid;
   logic              capture_req;
   logic [DATA_W-1:0] store_q;
   logic              valid_q;
   logic              oe_q;

   assign pin_raw.din_bus      = DIN_BUS_I;
   assign pin_raw.capture_en_n = CAPTURE_EN_N_I;
   assign pin_raw.drive_en_n   = DRIVE_EN_N_I;

   // Three-stage chain; only the second stage reads the first.
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         s1_q <= bus_reg_pkg::PIN_RST;
         s2_q <= bus_reg_pkg::PIN_RST;
         s3_q <= bus_reg_pkg::PIN_RST;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Each bit takes a new level only when the second and third stages agree.
   generate
      for (genvar b = 0; b < bus_reg_pkg::SYNC_W; b++) begin : g_filt
         assign filt_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : filt_q[b];
      end
   endgenerate

   // Filtered copy of the pins; a bit that is still settling keeps its old level.
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         filt_q <= bus_reg_pkg::PIN_RST;
      end else begin
         filt_q <= filt_d; // RULE_07
      end
   end

   // ==========================================================================
   // Capture path through the word buffer
   // ==========================================================================

   // A capture is taken on every clock edge while the enable is low, whatever
   // the drive enable does; a full buffer refuses it.
   assign capture_req = ~filt_q.capture_en_n; // RULE_02 RULE_06

   word_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_word_fifo (
      .clk_i       (MCLK_I),
      .arst_n_i    (ARST_N_I),
      .in_data_i   (filt_q.din_bus),
      .in_valid_i  (capture_req),
      .in_ready_o  (CAPTURE_READY_O),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (~UPDATE_HOLD_I)
   );

   // Stored word loads straight, uninverted, from the buffer and otherwise holds.
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         store_q <= bus_reg_pkg::STORE_RST;
      end else if (fifo_valid && !UPDATE_HOLD_I) begin
         store_q <= fifo_data; // RULE_01 RULE_02
      end else begin
         store_q <= store_q; // RULE_03
      end
   end

   // Marks that the stored word came from a real capture; until then the store
   // holds only its reset value, which users must not treat as data.
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         valid_q <= 1'b0;
      end else if (fifo_valid && !UPDATE_HOLD_I) begin
         valid_q <= 1'b1; // RULE_08
      end
   end

   // ==========================================================================
   // Output drive
   // ==========================================================================

   // Drive enable is registered so every pin switches together.
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= ~filt_q.drive_en_n; // RULE_04 RULE_05
      end
   end

   // Value on the pins always follows the store; the enable alone releases them.
   assign QOUT_BUS_O    = store_q; // RULE_04
   assign QOUT_OE_O     = {DATA_W{oe_q}}; // RULE_05
   assign STORE_VALID_O = valid_q;

endmodule : bus_register

// File: include/bus_reg_pkg.sv
// Shared constants and carrier types for the twenty-bit capture register.
package bus_reg_pkg;

   // ==========================================================================
   // Widths and depths
   // ==========================================================================
   localparam int DATA_W     = 20;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_W     = DATA_W + 2;

   // ==========================================================================
   // Values after reset
   // ==========================================================================
   localparam logic [DATA_W-1:0] STORE_RST  = 20'h00000;
   localparam logic              CAP_N_RST  = 1'h1;
   localparam logic              DRV_N_RST  = 1'h1;

   // ==========================================================================
   // Carrier for the pin inputs as they travel through the synchroniser
   // ==========================================================================
   typedef struct packed {
      logic [DATA_W-1:0] din_bus;
      logic              capture_en_n;
      logic              drive_en_n;
   } pin_in_type;

   localparam pin_in_type PIN_RST = '{din_bus:      20'h00000,
                                      capture_en_n: CAP_N_RST,
                                      drive_en_n:   DRV_N_RST};

endpackage : bus_reg_pkg

// File: bench/bus_register_properties.sv
// Port timing properties of the twenty-bit capture register.
`timescale 1ns/1ns
module bus_register_properties #(
   parameter int DATA_W = 20
) (
   input wire logic              MCLK_I,
   input wire logic              ARST_N_I,
   input wire logic [DATA_W-1:0] DIN_BUS_I,
   input wire logic              CAPTURE_EN_N_I,
   input wire logic              DRIVE_EN_N_I,
   input wire logic              UPDATE_HOLD_I,
   input wire logic [DATA_W-1:0] QOUT_BUS_O,
   input wire logic [DATA_W-1:0] QOUT_OE_O,
   input wire logic              CAPTURE_READY_O,
   input wire logic              STORE_VALID_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!ARST_N_I);
   // Sixteen quiet cycles empty the pipeline and the buffer.
   sequence s_quiet;
      (CAPTURE_EN_N_I && !UPDATE_HOLD_I)[*8] ##1 (CAPTURE_EN_N_I && !UPDATE_HOLD_I)[*8];
   endsequence
   // Seven capture cycles holding one settled word.
   sequence s_load;
      (!CAPTURE_EN_N_I && !UPDATE_HOLD_I) ##1
      (!CAPTURE_EN_N_I && !UPDATE_HOLD_I && $stable(DIN_BUS_I))[*6];
   endsequence
   a_drive_on: assert property ((!DRIVE_EN_N_I)[*6] |-> &QOUT_OE_O)
      else $error("outputs not driven");
   a_drive_off: assert property (DRIVE_EN_N_I[*6] |-> QOUT_OE_O == '0)
      else $error("outputs not released");
   a_oe_uniform: assert property (&QOUT_OE_O || QOUT_OE_O == '0)
      else $error("output enables differ");
   a_store_hold: assert property (s_quiet |-> $stable(QOUT_BUS_O))
      else $error("store changed without capture");
   a_ready_free: assert property (s_quiet |-> CAPTURE_READY_O)
      else $error("buffer full when idle");
   a_store_load: assert property (s_quiet ##1 s_load |-> QOUT_BUS_O == DIN_BUS_I)
      else $error("store differs from input");
   a_valid_sticky: assert property (STORE_VALID_O |=> STORE_VALID_O)
      else $error("store valid dropped");
endmodule : bus_register_properties

bind bus_register bus_register_properties #(
   .DATA_W (DATA_W)
) u_props (
   .MCLK_I          (MCLK_I),
   .ARST_N_I        (ARST_N_I),
   .DIN_BUS_I       (DIN_BUS_I),
   .CAPTURE_EN_N_I  (CAPTURE_EN_N_I),
   .DRIVE_EN_N_I    (DRIVE_EN_N_I),
   .UPDATE_HOLD_I   (UPDATE_HOLD_I),
   .QOUT_BUS_O      (QOUT_BUS_O),
   .QOUT_OE_O       (QOUT_OE_O),
   .CAPTURE_READY_O (CAPTURE_READY_O),
   .STORE_VALID_O   (STORE_VALID_O)
);

// File: bench/bus_side_model.sv
// Model of the bus-side logic feeding data and enables.
`timescale 1ns/1ns
module bus_side_model (
   input  wire logic                          clk_i,
   output logic [bus_reg_pkg::DATA_W-1:0]  din_o,
   output logic                            cap_n_o,
   output logic                            drv_n_o
);
   // Lines start with capture and drive disabled.
   initial begin
      din_o = '0;
      cap_n_o = 1'b1;
      drv_n_o = 1'b1;
   end
   // Presents a setting just after an edge and holds it settled for n edges.
   task automatic drive(input logic [bus_reg_pkg::DATA_W-1:0] w, input logic c_n,
                        input logic d_n, input int n);
      @(posedge clk_i);
      #1;
      din_o = w;
      cap_n_o = c_n;
      drv_n_o = d_n;
      repeat (n) @(posedge clk_i);
      #1;
      cap_n_o = 1'b1;
      din_o = ~w; // Idle data is the inverse so no stale copy helps.
   endtask : drive
endmodule : bus_side_model

// File: bench/test_bus_register.sv
// Self-checking testbench for the twenty-bit capture register.
`timescale 1ns/1ns
module test_bus_register;
   localparam int W = bus_reg_pkg::DATA_W;
   logic         mclk   = 1'b0;
   logic         arst_n = 1'b0;
   logic         hold   = 1'b0;
   logic [W-1:0] din, qout, oe;
   logic         cap_n, drv_n, ready, valid;
   int           bad_count       = 0;
   int           samples_checked = 0;
   // Clock of 8 ns.
   always #4 mclk = ~mclk;
   bus_side_model u_bus_side_model (.clk_i(mclk), .din_o(din), .cap_n_o(cap_n), .drv_n_o(drv_n));
   bus_register u_bus_register (.MCLK_I(mclk), .ARST_N_I(arst_n), .DIN_BUS_I(din),
      .CAPTURE_EN_N_I(cap_n), .DRIVE_EN_N_I(drv_n), .UPDATE_HOLD_I(hold), .QOUT_BUS_O(qout),
      .QOUT_OE_O(oe), .CAPTURE_READY_O(ready), .STORE_VALID_O(valid));
   // Compares one value and reports a mismatch.
   task automatic chk(input string nm, input logic [W-1:0] exp, input logic [W-1:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // Captures a word with outputs driven.
   task automatic t_capture();
      u_bus_side_model.drive(20'h5A3C1, 1'b0, 1'b0, 8);
      chk("qout", 20'h5A3C1, qout);
      chk("oe", '1, oe);
      chk("valid", W'(1), W'(valid));
   endtask : t_capture
   // New data without capture leaves the store alone.
   task automatic t_hold();
      u_bus_side_model.drive(20'hA5C3E, 1'b1, 1'b0, 18);
      chk("qout", 20'h5A3C1, qout);
   endtask : t_hold
   // Captures the inverse word with outputs released.
   task automatic t_hidden();
      u_bus_side_model.drive(20'hA5C3E, 1'b0, 1'b1, 8);
      chk("oe", '0, oe);
      chk("qout", 20'hA5C3E, qout);
   endtask : t_hidden
   // Stalls the buffer until it refuses, then drains it.
   task automatic t_full();
      @(posedge mclk);
      #1 hold = 1'b1;
      u_bus_side_model.drive(20'h0F0F0, 1'b0, 1'b0, 12);
      chk("ready", W'(0), W'(ready));
      hold = 1'b0;
      repeat (12) @(posedge mclk);
      #1;
      chk("ready", W'(1), W'(ready));
      chk("qout", 20'h0F0F0, qout);
   endtask : t_full
   // Resets in mid-run, checks the reset levels, then captures again.
   task automatic t_reset();
      @(posedge mclk);
      #1 arst_n = 1'b0;
      #1;
      chk("oe", '0, oe);
      chk("valid", W'(0), W'(valid));
      chk("ready", W'(1), W'(ready));
      repeat (2) @(posedge mclk);
      #1 arst_n = 1'b1;
      u_bus_side_model.drive(20'h3C5A7, 1'b0, 1'b0, 8);
      chk("qout", 20'h3C5A7, qout);
      chk("valid", W'(1), W'(valid));
   endtask : t_reset
   // Reset for two cycles, then the scenarios.
   initial begin
      repeat (2) @(posedge mclk);
      #1 arst_n = 1'b1;
      t_capture();
      t_hold();
      t_hidden();
      t_full();
      t_reset();
      results();
   end
   // Watchdog cuts a hang short.
   initial begin
      #2000;
      bad_count++;
      results();
   end
endmodule : test_bus_register
